// ==== hdl/gpio_clr_params.svh ====
`ifndef GPIO_CLR_PARAMS_SVH
`define GPIO_CLR_PARAMS_SVH


// Documented register byte addresses
`define PORT0_CLR_ADDR    32'hFFFF0D28
`define PORT1_CLR_ADDR    32'hFFFF0D38
`define PORT2_CLR_ADDR    32'hFFFF0D48

// Data registers and the reserved-write status register
`define PORT0_DATA_ADDR   32'hFFFF0D20
`define PORT1_DATA_ADDR   32'hFFFF0D30
`define PORT2_DATA_ADDR   32'hFFFF0D40
`define RSVD_STATUS_ADDR  32'hFFFF0D50

// Implemented bits of each port, in the upper half-word
`define PORT0_PIN_MASK    32'h001F0000
`define PORT1_PIN_MASK    32'h00030000
`define PORT2_PIN_MASK    32'h00630000

// Field positions of the pin bits
`define PORT0_PIN_LSB     16
`define PORT1_PIN_LSB     16
`define PORT2_LO_LSB      16
`define PORT2_HI_LSB      21

// Reset values
`define CLR_RESET         32'h00000000
`define DATA_RESET        32'h00000000
`define RSVD_STATUS_RESET 3'h0

`endif

// ==== hdl/gpio_clr_pkg.sv ====
package gpio_clr_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    // port0: ext_pin_4..0, port1: ext_pin_6..5,
    // port2: ext_pin_13, ext_pin_12, ext_pin_8, ext_pin_7
    typedef struct packed {
        logic [4:0] port0;
        logic [1:0] port1;
        logic [3:0] port2;
    } pins_type;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b01,
        BUS_READY = 2'b10
    } bus_state_type;

endpackage : gpio_clr_pkg

// ==== hdl/pin_clear_port.sv ====
`include "gpio_clr_params.svh"

module pin_clear_port #(
    parameter logic [31:0] PIN_MASK = `PORT0_PIN_MASK
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        clr_wr,
    input  wire logic        data_wr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] clr_q,
    output logic      [31:0] out_q,
    output logic             rsvd_hit
);

    logic [31:0] clr_d;
    logic [31:0] out_d;
    logic [31:0] pin_bits;

    assign pin_bits = wdata & PIN_MASK;

    // Reserved bits written non-zero to the clear register are flagged; data writes are not checked
    assign rsvd_hit = clr_wr & (|(wdata & ~PIN_MASK));

    always_comb begin
        clr_d = clr_q;
        out_d = out_q;
        if (data_wr) begin
            out_d = pin_bits;
        end
        if (clr_wr) begin
            clr_d = pin_bits;
            out_d = out_q & ~pin_bits;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clr_q <= `CLR_RESET;
            out_q <= `DATA_RESET;
        end else if (clk_en) begin
            clr_q <= clr_d;
            out_q <= out_d;
        end
    end

endmodule : pin_clear_port

// ==== hdl/gpio_pin_clear_registers.sv ====
`include "gpio_clr_params.svh"

module gpio_pin_clear_registers (
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic                     clk_en,
    input  wire gpio_clr_pkg::apb_req_type apb_req,
    output logic                          pready,
    output logic                   [31:0] prdata,
    output logic                          pslverr,
    output gpio_clr_pkg::pins_type        pins
);

    gpio_clr_pkg::bus_state_type state_q;
    gpio_clr_pkg::bus_state_type state_d;

    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;
    logic        err_d;
    logic [2:0]  rsvd_q;
    logic [2:0]  rsvd_d;

    logic        sel_clr0;
    logic        sel_clr1;
    logic        sel_clr2;
    logic        sel_dat0;
    logic        sel_dat1;
    logic        sel_dat2;
    logic        sel_stat;
    logic        mapped;
    logic        wr_fire;

    logic [31:0] clr0_q;
    logic [31:0] clr1_q;
    logic [31:0] clr2_q;
    logic [31:0] out0_q;
    logic [31:0] out1_q;
    logic [31:0] out2_q;
    logic [2:0]  rsvd_hit;

    // Full 32-bit compare: aliases would let stray writes clear pins
    assign sel_clr0 = (apb_req.paddr == `PORT0_CLR_ADDR);
    assign sel_clr1 = (apb_req.paddr == `PORT1_CLR_ADDR);
    assign sel_clr2 = (apb_req.paddr == `PORT2_CLR_ADDR);
    assign sel_dat0 = (apb_req.paddr == `PORT0_DATA_ADDR);
    assign sel_dat1 = (apb_req.paddr == `PORT1_DATA_ADDR);
    assign sel_dat2 = (apb_req.paddr == `PORT2_DATA_ADDR);
    assign sel_stat = (apb_req.paddr == `RSVD_STATUS_ADDR);

    assign mapped = sel_clr0 | sel_clr1 | sel_clr2 |
                    sel_dat0 | sel_dat1 | sel_dat2 | sel_stat;

    // Ready only once read data is registered and state may advance
    assign pready = apb_req.psel & apb_req.penable & clk_en &
                    (state_q == gpio_clr_pkg::BUS_READY);

    // Writes commit only at the completing access edge
    assign wr_fire = pready & apb_req.pwrite & mapped;

    assign prdata  = rdata_q;
    assign pslverr = err_q & pready;

    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        case (state_q)
            gpio_clr_pkg::BUS_IDLE: begin
                if (apb_req.psel) begin
                    state_d = gpio_clr_pkg::BUS_READY;
                    err_d   = ~mapped;
                    rdata_d = 32'h00000000;
                    if (!apb_req.pwrite) begin
                        if (sel_clr0) begin
                            rdata_d = clr0_q;
                        end
                        if (sel_clr1) begin
                            rdata_d = clr1_q;
                        end
                        if (sel_clr2) begin
                            rdata_d = clr2_q;
                        end
                        if (sel_dat0) begin
                            rdata_d = out0_q;
                        end
                        if (sel_dat1) begin
                            rdata_d = out1_q;
                        end
                        if (sel_dat2) begin
                            rdata_d = out2_q;
                        end
                        if (sel_stat) begin
                            rdata_d = {29'h00000000, rsvd_q};
                        end
                    end
                end
            end
            gpio_clr_pkg::BUS_READY: begin
                if (pready) begin
                    state_d = gpio_clr_pkg::BUS_IDLE;
                end
            end
            default: begin
                state_d = gpio_clr_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= gpio_clr_pkg::BUS_IDLE;
            rdata_q <= 32'h00000000;
            err_q   <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    pin_clear_port #(
        .PIN_MASK (`PORT0_PIN_MASK)
    ) u_port0 (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .clr_wr   (wr_fire & sel_clr0),
        .data_wr  (wr_fire & sel_dat0),
        .wdata    (apb_req.pwdata),
        .clr_q    (clr0_q),
        .out_q    (out0_q),
        .rsvd_hit (rsvd_hit[0])
    );

    pin_clear_port #(
        .PIN_MASK (`PORT1_PIN_MASK)
    ) u_port1 (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .clr_wr   (wr_fire & sel_clr1),
        .data_wr  (wr_fire & sel_dat1),
        .wdata    (apb_req.pwdata),
        .clr_q    (clr1_q),
        .out_q    (out1_q),
        .rsvd_hit (rsvd_hit[1])
    );

    pin_clear_port #(
        .PIN_MASK (`PORT2_PIN_MASK)
    ) u_port2 (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .clr_wr   (wr_fire & sel_clr2),
        .data_wr  (wr_fire & sel_dat2),
        .wdata    (apb_req.pwdata),
        .clr_q    (clr2_q),
        .out_q    (out2_q),
        .rsvd_hit (rsvd_hit[2])
    );

    // reserved-bit writes to the clear registers flagged; a new hit wins over a W1C
    always_comb begin
        rsvd_d = rsvd_q;
        if (wr_fire & sel_stat) begin
            rsvd_d = rsvd_q & ~apb_req.pwdata[2:0];
        end
        rsvd_d = rsvd_d | rsvd_hit;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rsvd_q <= `RSVD_STATUS_RESET;
        end else if (clk_en) begin
            rsvd_q <= rsvd_d;
        end
    end

    assign pins.port0 = out0_q[`PORT0_PIN_LSB +: 5];
    assign pins.port1 = out1_q[`PORT1_PIN_LSB +: 2];
    assign pins.port2 = {out2_q[`PORT2_HI_LSB +: 2], out2_q[`PORT2_LO_LSB +: 2]};

endmodule : gpio_pin_clear_registers

// ==== dv/ext_pins_model.sv ====
module ext_pins_model (
    input  wire gpio_clr_pkg::pins_type pins,
    output gpio_clr_pkg::pins_type      level
);
    timeunit 1ns;
    timeprecision 1ns;
    // Push-pull outputs with no pull, so each line follows its drive
    assign level = pins;
endmodule : ext_pins_model

// ==== dv/gpio_clr_assertions.sv ====
`include "gpio_clr_params.svh"
module gpio_clr_checker (
    input wire logic                      mclk,
    input wire logic                      sys_rst,
    input wire logic                      clk_en,
    input wire gpio_clr_pkg::apb_req_type apb_req,
    input wire logic                      pready,
    input wire logic [31:0]               prdata,
    input wire logic                      pslverr,
    input wire gpio_clr_pkg::pins_type    pins
);
    logic        wr;
    logic        rd;
    logic [31:0] d;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
    assign rd = pready && !apb_req.pwrite;
    assign d = apb_req.pwdata;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    port0_clear_a: assert property (wr && apb_req.paddr == `PORT0_CLR_ADDR |=>
        pins.port0 == ($past(pins.port0) & ~$past(d[20:16]))) else $error("port 0 clear");
    port1_clear_a: assert property (wr && apb_req.paddr == `PORT1_CLR_ADDR |=>
        pins.port1 == ($past(pins.port1) & ~$past(d[17:16]))) else $error("port 1 clear");
    port2_clear_a: assert property (wr && apb_req.paddr == `PORT2_CLR_ADDR |=>
        pins.port2 == ($past(pins.port2) & ~{$past(d[22:21]), $past(d[17:16])}))
        else $error("port 2 clear");
    pins_hold_a: assert property (!wr |=> $stable(pins)) else $error("pins moved");
    other_ports_a: assert property (wr && apb_req.paddr == `PORT2_CLR_ADDR |=>
        $stable({pins.port0, pins.port1})) else $error("other port moved");
    clr_read_a: assert property (rd && apb_req.paddr == `PORT1_CLR_ADDR |->
        (prdata & ~`PORT1_PIN_MASK) == 32'h0) else $error("clear word bits");
    data_read_a: assert property (rd && apb_req.paddr == `PORT0_DATA_ADDR |->
        prdata[20:16] == pins.port0) else $error("data read");
    clear_c: cover property (wr && apb_req.paddr == `PORT2_CLR_ADDR);
    stall_c: cover property (apb_req.penable && !clk_en);
    error_c: cover property (pready && pslverr);
endmodule : gpio_clr_checker
bind gpio_pin_clear_registers gpio_clr_checker chk (.mclk(mclk), .sys_rst(sys_rst),
    .clk_en(clk_en), .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pins(pins));

// ==== dv/tb.sv ====
`include "gpio_clr_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      mclk = 1'b0;
    logic                      sys_rst = 1'b1;
    logic                      clk_en = 1'b1;
    gpio_clr_pkg::apb_req_type req = '0;
    logic                      pready;
    logic [31:0]               prdata;
    logic                      pslverr;
    gpio_clr_pkg::pins_type    pins;
    gpio_clr_pkg::pins_type    level;
    gpio_clr_pkg::pins_type    ex = '0;
    logic [31:0]               rd;
    logic                      err;
    logic [31:0]               v;
    integer                    seed = 32'hbff25648;
    int                        mismatches = 0;
    int                        num_checks = 0;
    int                        n;
    localparam logic [31:0] CLR [3] = '{`PORT0_CLR_ADDR, `PORT1_CLR_ADDR, `PORT2_CLR_ADDR};
    localparam logic [31:0] DAT [3] = '{`PORT0_DATA_ADDR, `PORT1_DATA_ADDR, `PORT2_DATA_ADDR};
    localparam logic [31:0] MSK [3] = '{`PORT0_PIN_MASK, `PORT1_PIN_MASK, `PORT2_PIN_MASK};
    always #25 mclk = ~mclk;
    // Random stalls stretch the access phase
    always @(posedge mclk) begin
        if (!sys_rst) begin
            clk_en <= ($random(seed) & 3) != 0;
        end
    end
    gpio_pin_clear_registers DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pins(pins));
    ext_pins_model far (.pins(pins), .level(level));
    function automatic gpio_clr_pkg::pins_type apply(gpio_clr_pkg::pins_type p,
                                                     logic [31:0] a, logic [31:0] d);
        case (a)
            `PORT0_DATA_ADDR: p.port0 = d[20:16];
            `PORT1_DATA_ADDR: p.port1 = d[17:16];
            `PORT2_DATA_ADDR: p.port2 = {d[22:21], d[17:16]};
            `PORT0_CLR_ADDR: p.port0 &= ~d[20:16];
            `PORT1_CLR_ADDR: p.port1 &= ~d[17:16];
            `PORT2_CLR_ADDR: p.port2 &= ~{d[22:21], d[17:16]};
            default: ;
        endcase
        return p;
    endfunction : apply
    function automatic logic [31:0] word(gpio_clr_pkg::pins_type p, int k);
        if (k == 0) return {11'h0, p.port0, 16'h0};
        if (k == 1) return {14'h0, p.port1, 16'h0};
        return {9'h0, p.port2[3:2], 3'h0, p.port2[1:0], 16'h0};
    endfunction : word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, ad, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (w) ex = apply(ex, ad, d);
        @(negedge mclk);
    endtask : xfer
    task automatic test_done;
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #1000000;
        mismatches++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        for (n = 0; n < 3; n++) begin
            xfer(1'b0, CLR[n], 32'h0);
            chk(rd, 32'h0);
            xfer(1'b1, DAT[n], MSK[n]);
            xfer(1'b1, CLR[n], 32'h0);
            chk(32'(level), 32'(ex));
        end
        xfer(1'b1, CLR[2], 32'h00600000);
        chk(32'(level), 32'(ex));
        for (int i = 0; i < 60; i++) begin
            n = ($random(seed) & 32'h7FFFFFFF) % 3;
            xfer(1'b1, DAT[n], $random(seed) & MSK[n]);
            v = $random(seed) & MSK[n];
            xfer(1'b1, CLR[n], v);
            chk(32'(level), 32'(ex));
            xfer(1'b0, CLR[n], 32'h0);
            chk(rd, v);
            xfer(1'b0, DAT[n], 32'h0);
            chk(rd, word(ex, n));
        end
        xfer(1'b0, `RSVD_STATUS_ADDR, 32'h0);
        chk(rd, 32'h0);
        // Deliberate reserved-bit write: pins must not move, flag must set
        xfer(1'b1, CLR[1], 32'h00000001);
        chk(32'(level), 32'(ex));
        xfer(1'b0, `RSVD_STATUS_ADDR, 32'h0);
        chk(rd, 32'h2);
        xfer(1'b1, `RSVD_STATUS_ADDR, 32'h2);
        xfer(1'b0, `RSVD_STATUS_ADDR, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, `RSVD_STATUS_ADDR + 32'h4, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Drive port 0 high so the mid-run reset has something to clear
        xfer(1'b1, DAT[0], MSK[0]);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        ex = '0;
        @(negedge mclk);
        chk(32'(level), 32'(ex));
        xfer(1'b0, CLR[0], 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, DAT[0], 32'h0);
        chk(rd, word(ex, 0));
        test_done;
    end
endmodule : tb
